// >>> verilog/srb_regs.vh
`ifndef SRB_REGS_VH
`define SRB_REGS_VH
// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define SRB_ADDR_W 7
`define SRB_DATA_W 16
`define SRB_RES_W 12
`define SRB_CH_W 6
`define SRB_ADDR_TEMP 7'h00
`define SRB_ADDR_CORE 7'h01
`define SRB_ADDR_AUX 7'h02
`define SRB_ADDR_BRAM 7'h06
`define SRB_ADDR_PCORE 7'h0d
`define SRB_ADDR_PAUX 7'h0e
`define SRB_ADDR_MEMIO 7'h0f
// max/min tracking blocks, one register per tracked sensor in its max block and its min block
`define SRB_ADDR_MAX_BASE 7'h20
`define SRB_ADDR_MIN_BASE 7'h24
`define SRB_ADDR_PMAX_BASE 7'h28
`define SRB_ADDR_PMIN_BASE 7'h2c
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define SRB_CTRL_BIT 6
`define SRB_CFG0_IDX 6'h00
`define SRB_CFG0_BIPOLAR_BIT 10
`define SRB_STAT_RST 16'h0000
`define SRB_CTRL_RST 16'h0000
`define SRB_MAX_RST 16'h0000
`define SRB_MIN_RST 16'hffff
`endif

// >>> verilog/srb_result_bank.v
// Notes on behaviour
// - die temperature is taken as a 12-bit converter code
// - degrees C equal code times 503.975 over 4096 minus 273.15
// - temperature result lands in status register 00h
// - supply codes represent code over 4096 times 3 V after divide-by-three
// - core, aux and block-memory supply results go to 01h, 02h, 06h
// - processor supplies go to 0Dh, 0Eh, 0Fh on processor variants
// - port decodes a 7-bit address over 128 registers of 16 bits
// - addresses 00h to 3Fh are read-only result registers
// - addresses 40h to 7Fh are read-write control registers
// - fabric port and JTAG side both reach registers through an arbiter
// - each channel result goes to the register matching its channel number
// - max and min per on-chip sensor tracked, restarted on reset
// - unipolar results are straight binary
// - bipolar results are two's complement
// - 12-bit result sits left-justified in the 16-bit register
`include "srb_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module srb_result_bank #(
   parameter HAS_PROC = 1
)
(
   // clock and reset
   input wire REF_CLK_I,
   input wire RST_N_I,
   // conversion results from the converter core
   input wire CONV_VALID_I,
   input wire [5:0] CONV_CHANNEL_I,
   input wire [11:0] CONV_CODE_I,
   // fabric side register port
   input wire FAB_EN_I,
   input wire FAB_WE_I,
   input wire [6:0] FAB_ADDR_I,
   input wire [15:0] FAB_DI_I,
   output reg [15:0] FAB_DO_O,
   output wire FAB_RDY_O,
   // jtag side register port
   input wire JTAG_EN_I,
   input wire JTAG_WE_I,
   input wire [6:0] JTAG_ADDR_I,
   input wire [15:0] JTAG_DI_I,
   output reg [15:0] JTAG_DO_O,
   output wire JTAG_RDY_O,
   // configuration out
   output wire BIPOLAR_MODE_O
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // raw code is offset binary from the core; bipolar flips msb to two's complement
   function [15:0] srb_justify;
      input [11:0] code;
      input bip;
      begin
         srb_justify = {code[11] ^ bip, code[10:0], 4'h0};
      end
   endfunction

   // compare in the coding the register actually holds
   function srb_greater;
      input [15:0] a;
      input [15:0] b;
      input bip;
      begin
         if (bip)
            srb_greater = $signed(a) > $signed(b);
         else
            srb_greater = a > b;
      end
   endfunction

   // maps sensor channel to tracker slot 0..2 or 3..6; 7 means not tracked
   function [2:0] srb_slot;
      input [5:0] ch;
      begin
         case (ch)
            6'h00: srb_slot = 3'd0;
            6'h01: srb_slot = 3'd1;
            6'h02: srb_slot = 3'd2;
            6'h06: srb_slot = 3'd3;
            6'h0d: srb_slot = 3'd4;
            6'h0e: srb_slot = 3'd5;
            6'h0f: srb_slot = 3'd6;
            default: srb_slot = 3'd7;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // arbiter
   // ------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_FAB = 3'b010;
   localparam ST_JTAG = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg last_jtag_reg;
   reg last_jtag_next;
   reg fab_rdy_reg;
   reg jtag_rdy_reg;

   reg acc_en;
   reg acc_we;
   reg [6:0] acc_addr;
   reg [15:0] acc_di;

   // one access per cycle; round-robin so neither requester can starve
   always @*
   begin
      state_next = ST_IDLE;
      last_jtag_next = last_jtag_reg;
      acc_en = 1'b0;
      acc_we = 1'b0;
      acc_addr = 7'h00;
      acc_di = 16'h0000;
      case (state_reg)
         ST_IDLE, ST_FAB, ST_JTAG:
         begin
            if (FAB_EN_I && (!JTAG_EN_I || last_jtag_reg))
            begin
               state_next = ST_FAB;
               last_jtag_next = 1'b0;
               acc_en = 1'b1;
               acc_we = FAB_WE_I;
               acc_addr = FAB_ADDR_I;
               acc_di = FAB_DI_I;
            end
            else if (JTAG_EN_I)
            begin
               state_next = ST_JTAG;
               last_jtag_next = 1'b1;
               acc_en = 1'b1;
               acc_we = JTAG_WE_I;
               acc_addr = JTAG_ADDR_I;
               acc_di = JTAG_DI_I;
            end
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   reg [15:0] status_mem [0:63];
   reg [15:0] ctrl_mem [0:63];
   reg [15:0] max_reg [0:6];
   reg [15:0] min_reg [0:6];

   wire bipolar = ctrl_mem[`SRB_CFG0_IDX][`SRB_CFG0_BIPOLAR_BIT];
   assign BIPOLAR_MODE_O = bipolar;

   // sensors are always unipolar, only external channels follow the mode
   wire conv_bip = bipolar && (CONV_CHANNEL_I == 6'h03 || CONV_CHANNEL_I[5:4] == 2'b01);
   wire [15:0] conv_word = srb_justify(CONV_CODE_I, conv_bip);
   wire [2:0] conv_slot = srb_slot(CONV_CHANNEL_I);
   wire proc_ch = (CONV_CHANNEL_I == 6'h0d) || (CONV_CHANNEL_I == 6'h0e) || (CONV_CHANNEL_I == 6'h0f);
   wire conv_take = CONV_VALID_I && (HAS_PROC != 0 || !proc_ch);
   wire [6:0] max_sum = (conv_slot < 3'd3) ? (`SRB_ADDR_MAX_BASE + {4'h0, conv_slot}) :
                        (`SRB_ADDR_PMAX_BASE + {4'h0, conv_slot} - 7'h03);
   wire [6:0] min_sum = (conv_slot < 3'd3) ? (`SRB_ADDR_MIN_BASE + {4'h0, conv_slot}) :
                        (`SRB_ADDR_PMIN_BASE + {4'h0, conv_slot} - 7'h03);
   wire [5:0] max_addr = max_sum[5:0];
   wire [5:0] min_addr = min_sum[5:0];

   // slot 7 has no tracker; it looks at slot 0 but its update is gated off
   wire [2:0] trk_idx = (conv_slot == 3'd7) ? 3'd0 : conv_slot;
   wire [15:0] mx = max_reg[trk_idx];
   wire [15:0] mn = min_reg[trk_idx];
   wire trk_ch = conv_take && conv_slot != 3'd7;
   wire upd_max = trk_ch && srb_greater(conv_word, mx, 1'b0);
   wire upd_min = trk_ch && srb_greater(mn, conv_word, 1'b0);

   // ------------------------------------------------------------
   // port decode
   // ------------------------------------------------------------
   wire acc_ctrl = acc_addr[`SRB_CTRL_BIT];
   wire [5:0] acc_idx = acc_addr[5:0];
   wire ctrl_wr = acc_en && acc_we && acc_ctrl;
   wire fab_take = acc_en && state_next == ST_FAB;
   wire jtag_take = acc_en && state_next == ST_JTAG;

   // read word of the granted access; a same-cycle write is not forwarded
   reg [15:0] rd_word;
   always @*
   begin
      rd_word = 16'h0000;
      if (acc_ctrl)
         rd_word = ctrl_mem[acc_idx];
      else
         rd_word = status_mem[acc_idx];
   end

   integer k_st;
   integer k_trk;
   integer k_ctl;

   // ------------------------------------------------------------
   // arbiter state register
   // ------------------------------------------------------------
   always @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_reg <= ST_IDLE;
         last_jtag_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         last_jtag_reg <= last_jtag_next;
      end
   end

   // ------------------------------------------------------------
   // result storage
   // ------------------------------------------------------------
   // the temperature code is left unscaled: degrees are code*503.975/4096-273.15 in software
   always @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         for (k_st = 0; k_st < 64; k_st = k_st + 1)
            status_mem[k_st] <= `SRB_STAT_RST;
         // min mirrors must read as their tracker's start value, not as zero
         for (k_st = 0; k_st < 3; k_st = k_st + 1)
            status_mem[`SRB_ADDR_MIN_BASE + k_st] <= `SRB_MIN_RST;
         for (k_st = 0; k_st < 4; k_st = k_st + 1)
            status_mem[`SRB_ADDR_PMIN_BASE + k_st] <= `SRB_MIN_RST;
      end
      else
      begin
         if (conv_take)
            status_mem[CONV_CHANNEL_I] <= conv_word;
         // mirrors sit at 20h-2Fh; a channel number in that range would collide
         if (upd_max)
            status_mem[max_addr] <= conv_word;
         if (upd_min)
            status_mem[min_addr] <= conv_word;
      end
   end

   // ------------------------------------------------------------
   // trackers
   // ------------------------------------------------------------
   always @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         for (k_trk = 0; k_trk < 7; k_trk = k_trk + 1)
         begin
            max_reg[k_trk] <= `SRB_MAX_RST;
            min_reg[k_trk] <= `SRB_MIN_RST;
         end
      end
      else
      begin
         if (upd_max)
            max_reg[trk_idx] <= conv_word;
         if (upd_min)
            min_reg[trk_idx] <= conv_word;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         for (k_ctl = 0; k_ctl < 64; k_ctl = k_ctl + 1)
            ctrl_mem[k_ctl] <= `SRB_CTRL_RST;
      end
      else
      begin
         // status half ignores writes but still answers
         if (ctrl_wr)
            ctrl_mem[acc_idx] <= acc_di;
      end
   end

   // ------------------------------------------------------------
   // responses
   // ------------------------------------------------------------
   always @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         fab_rdy_reg <= 1'b0;
         jtag_rdy_reg <= 1'b0;
         FAB_DO_O <= 16'h0000;
         JTAG_DO_O <= 16'h0000;
      end
      else
      begin
         fab_rdy_reg <= fab_take;
         jtag_rdy_reg <= jtag_take;
         // each port keeps its last read word until it is granted again
         if (fab_take)
            FAB_DO_O <= rd_word;
         if (jtag_take)
            JTAG_DO_O <= rd_word;
      end
   end

   assign FAB_RDY_O = fab_rdy_reg;
   assign JTAG_RDY_O = jtag_rdy_reg;

endmodule // srb_result_bank
`default_nettype wire

// >>> verification/srb_chk.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// port checker
// -----------------------------
module srb_chk (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic FAB_EN_I,
   input wire logic FAB_WE_I,
   input wire logic [6:0] FAB_ADDR_I,
   input wire logic [15:0] FAB_DI_I,
   input wire logic [15:0] FAB_DO_O,
   input wire logic FAB_RDY_O,
   input wire logic JTAG_EN_I,
   input wire logic JTAG_RDY_O,
   input wire logic BIPOLAR_MODE_O
);
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // a lone requester always wins the arbiter
   sequence s_fab;
      FAB_EN_I && !JTAG_EN_I;
   endsequence
   sequence s_jtg;
      JTAG_EN_I && !FAB_EN_I;
   endsequence
   a_fab_answer: assert property (s_fab |=> FAB_RDY_O) else $error("fab unanswered");
   a_jtag_answer: assert property (s_jtg |=> JTAG_RDY_O) else $error("jtag unanswered");
   a_fab_cause: assert property (FAB_RDY_O |-> $past(FAB_EN_I)) else $error("fab stray rdy");
   a_jtag_cause: assert property (JTAG_RDY_O |-> $past(JTAG_EN_I)) else $error("jtag stray rdy");
   a_one_grant: assert property (!(FAB_RDY_O && JTAG_RDY_O)) else $error("both granted");
   a_mode_write: assert property (s_fab ##0 (FAB_WE_I && FAB_ADDR_I == 7'h40)
      |=> BIPOLAR_MODE_O == $past(FAB_DI_I[10])) else $error("mode not written");
   a_ro_ignore: assert property (s_fab ##0 (FAB_WE_I && !FAB_ADDR_I[6])
      |=> $stable(BIPOLAR_MODE_O)) else $error("status write took");
   a_do_hold: assert property (!FAB_RDY_O |-> $stable(FAB_DO_O)) else $error("read data moved");
endmodule // srb_chk
bind srb_result_bank srb_chk i_chk (
   .REF_CLK_I(REF_CLK_I),
   .RST_N_I(RST_N_I),
   .FAB_EN_I(FAB_EN_I),
   .FAB_WE_I(FAB_WE_I),
   .FAB_ADDR_I(FAB_ADDR_I),
   .FAB_DI_I(FAB_DI_I),
   .FAB_DO_O(FAB_DO_O),
   .FAB_RDY_O(FAB_RDY_O),
   .JTAG_EN_I(JTAG_EN_I),
   .JTAG_RDY_O(JTAG_RDY_O),
   .BIPOLAR_MODE_O(BIPOLAR_MODE_O)
);
`default_nettype wire

// >>> verification/srb_req_mdl.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// register port requester
// -----------------------------
module srb_req_mdl (
   input wire logic clk_i,
   input wire logic rdy_i,
   input wire logic [15:0] do_i,
   output logic en_o,
   output logic we_o,
   output logic [6:0] a_o,
   output logic [15:0] d_o
);
   initial
   begin
      en_o = 1'b0;
      we_o = 1'b0;
      a_o = 7'h00;
      d_o = 16'h0000;
   end
   // one-cycle strobe; a lost request is not retried, ok tells
   // qualifiers stand for three edges after the strobe drops; data is taken at the ready edge
   task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic ok);
      ok = 1'b0;
      @(posedge clk_i);
      en_o <= 1'b1;
      we_o <= w;
      a_o <= a;
      d_o <= d;
      @(posedge clk_i);
      en_o <= 1'b0;
      repeat (3)
      begin
         @(posedge clk_i);
         if (rdy_i === 1'b1 && !ok)
         begin
            q = do_i;
            ok = 1'b1;
         end
      end
      // released address and data lines flip and write drops low so stale values cannot pass
      we_o <= 1'b0;
      a_o <= ~a;
      d_o <= ~d;
   endtask
endmodule // srb_req_mdl
`default_nettype wire

// >>> verification/srb_result_bank_tb_top.sv
`include "srb_regs.vh"
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// testbench top
// -----------------------------
module srb_result_bank_tb_top;
   logic REF_CLK_I = 1'b0;
   logic RST_N_I = 1'b0;
   logic CONV_VALID_I = 1'b0;
   logic [5:0] CONV_CHANNEL_I = 6'h00;
   logic [11:0] CONV_CODE_I = 12'h000;
   logic FAB_EN_I, FAB_WE_I, FAB_RDY_O, JTAG_EN_I, JTAG_WE_I, JTAG_RDY_O, BIPOLAR_MODE_O;
   logic [6:0] FAB_ADDR_I, JTAG_ADDR_I;
   logic [15:0] FAB_DI_I, FAB_DO_O, JTAG_DI_I, JTAG_DO_O;
   int n_mismatch = 0;
   int checks = 0;
   initial
   begin
      forever #2 REF_CLK_I = ~REF_CLK_I;
   end
   srb_result_bank #(.HAS_PROC(1)) i_srb_result_bank (
      .REF_CLK_I(REF_CLK_I),
      .RST_N_I(RST_N_I),
      .CONV_VALID_I(CONV_VALID_I),
      .CONV_CHANNEL_I(CONV_CHANNEL_I),
      .CONV_CODE_I(CONV_CODE_I),
      .FAB_EN_I(FAB_EN_I),
      .FAB_WE_I(FAB_WE_I),
      .FAB_ADDR_I(FAB_ADDR_I),
      .FAB_DI_I(FAB_DI_I),
      .FAB_DO_O(FAB_DO_O),
      .FAB_RDY_O(FAB_RDY_O),
      .JTAG_EN_I(JTAG_EN_I),
      .JTAG_WE_I(JTAG_WE_I),
      .JTAG_ADDR_I(JTAG_ADDR_I),
      .JTAG_DI_I(JTAG_DI_I),
      .JTAG_DO_O(JTAG_DO_O),
      .JTAG_RDY_O(JTAG_RDY_O),
      .BIPOLAR_MODE_O(BIPOLAR_MODE_O)
   );
   srb_req_mdl i_fab (.clk_i(REF_CLK_I), .rdy_i(FAB_RDY_O), .do_i(FAB_DO_O), .en_o(FAB_EN_I),
      .we_o(FAB_WE_I), .a_o(FAB_ADDR_I), .d_o(FAB_DI_I));
   srb_req_mdl i_jtg (.clk_i(REF_CLK_I), .rdy_i(JTAG_RDY_O), .do_i(JTAG_DO_O), .en_o(JTAG_EN_I),
      .we_o(JTAG_WE_I), .a_o(JTAG_ADDR_I), .d_o(JTAG_DI_I));
   task chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, s, e);
      end
   endtask
   // every access expects its ready, a read expects v back as well
   task automatic io(input logic w, input logic [6:0] a, input logic [15:0] v);
      logic [15:0] q;
      logic ok;
      i_fab.acc(w, a, v, q, ok);
      chk({15'h0000, ok}, 16'h0001);
      if (!w)
         chk(q, v);
   endtask
   task cnv(input logic [5:0] ch, input logic [11:0] c);
      @(posedge REF_CLK_I);
      CONV_VALID_I <= 1'b1;
      CONV_CHANNEL_I <= ch;
      CONV_CODE_I <= c;
      @(posedge REF_CLK_I);
      CONV_VALID_I <= 1'b0;
      @(posedge REF_CLK_I);
   endtask
   task do_rst;
      @(posedge REF_CLK_I);
      RST_N_I <= 1'b0;
      repeat (16) @(posedge REF_CLK_I);
      RST_N_I <= 1'b1;
   endtask
   task t_rst;
      io(1'b0, 7'h40, `SRB_CTRL_RST);
      io(1'b0, `SRB_ADDR_MAX_BASE, `SRB_MAX_RST);
      io(1'b0, `SRB_ADDR_MIN_BASE, `SRB_MIN_RST);
      $display("t_rst done");
   endtask
   task automatic t_cnv;
      logic [6:0] ch [8] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h0d, 7'h0e, 7'h0f, 7'h03};
      logic [11:0] c;
      for (int i = 0; i < 8; i++)
      begin
         c = 12'h5a0 + 12'(i);
         cnv(ch[i][5:0], c);
         io(1'b0, ch[i], {c, 4'h0});
      end
      cnv(6'h00, 12'h123);
      cnv(6'h00, 12'hf00);
      io(1'b0, `SRB_ADDR_MAX_BASE, 16'hf000);
      io(1'b0, `SRB_ADDR_MIN_BASE, 16'h1230);
      io(1'b0, `SRB_ADDR_PMAX_BASE, 16'h5a30);
      io(1'b0, `SRB_ADDR_PMIN_BASE + 7'h03, 16'h5a60);
      $display("t_cnv done");
   endtask
   task t_ro;
      io(1'b1, 7'h00, 16'hffff);
      io(1'b0, 7'h00, 16'hf000);
      io(1'b1, 7'h3f, 16'hffff);
      io(1'b0, 7'h3f, 16'h0000);
      $display("t_ro done");
   endtask
   task t_ctl;
      io(1'b1, 7'h40, 16'h0400);
      chk({15'h0000, BIPOLAR_MODE_O}, 16'h0001);
      cnv(6'h03, 12'h7ff);
      io(1'b0, 7'h03, 16'hfff0);
      io(1'b1, 7'h7f, 16'ha5a5);
      io(1'b0, 7'h7f, 16'ha5a5);
      io(1'b1, 7'h40, 16'h0000);
      chk({15'h0000, BIPOLAR_MODE_O}, 16'h0000);
      $display("t_ctl done");
   endtask
   task automatic t_arb;
      logic [15:0] qa, qb;
      logic oka, okb;
      i_jtg.acc(1'b1, 7'h7e, 16'h1234, qb, okb);
      chk({15'h0000, okb}, 16'h0001);
      io(1'b0, 7'h7e, 16'h1234);
      i_jtg.acc(1'b0, 7'h7f, 16'h0000, qb, okb);
      chk(qb, 16'ha5a5);
      fork
         i_fab.acc(1'b0, 7'h7f, 16'h0000, qa, oka);
         i_jtg.acc(1'b0, 7'h7f, 16'h0000, qb, okb);
      join
      chk({15'h0000, oka ^ okb}, 16'h0001);
      chk({15'h0000, oka}, 16'h0001);
      chk(qa, 16'ha5a5);
      $display("t_arb done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      do_rst();
      t_rst();
      t_cnv();
      t_ro();
      t_ctl();
      t_arb();
      do_rst();
      t_rst();
      end_sim();
   end
   // the whole run needs well under 2000 cycles
   initial
   begin
      #20000;
      n_mismatch++;
      end_sim();
   end
endmodule // srb_result_bank_tb_top
`default_nettype wire
